// [logic/tci_pkg.sv]
// tci_pkg: constants for the timer clock and signal interconnect block.
// assumes an axi4-lite master on mclk and three timer units beside it.
// Notes on behaviour
// - each timer counts on none, bus, fixed or external clock per its 2-bit source code.
// - the first serial transmit output can be modulated by the first timer's channel 0 pwm.
// - a set receive capture bit routes the first serial receive line to first timer channel 1.
// - a set comparator capture bit feeds the first comparator into channel 0 of the second timer.
// - a set counter capture bit routes the counter overflow to second timer channel 1.
// - third timer sync triggers are the comparator, first timer channel 0 and a software pulse.
// - third timer faults are the comparator, port a bit six, port a bit seven and a dead zero.
// - all sources of one timer merge into one request; software reads that timer's status.
package tci_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_OPTIONS = 8'h00;
  localparam logic [7:0] OFS_CLKSEL = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h0C;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h10;
  localparam logic [7:0] OFS_LIVE = 8'h14;
  // option register fields
  localparam int BIT_RXCAP = 0;
  localparam int BIT_CMPCAP = 1;
  localparam int BIT_RTCCAP = 2;
  localparam int BIT_TXMOD = 3;
  localparam int BIT_SYNC = 4;
  localparam int OPT_W = 4;
  localparam logic [OPT_W-1:0] OPT_RESET = 4'h0;
  // clock select fields: two bits per timer
  localparam int CLK_POS_A = 0;
  localparam int CLK_POS_B = 2;
  localparam int CLK_POS_C = 4;
  localparam logic [5:0] CLKSEL_RESET = 6'h00;
  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_BUS = 2'h1;
  localparam logic [1:0] SRC_FIXED = 2'h2;
  localparam logic [1:0] SRC_EXT = 2'h3;
  // interrupt status bits: one per merged timer request
  localparam int NUM_TIMERS = 3;
  localparam logic [NUM_TIMERS-1:0] IRQ_RESET = 3'h0;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    WR_IDLE = 3'b001,
    WR_TAKE = 3'b010,
    WR_RESP = 3'b100
  } tci_wr_type;
endpackage

// [logic/tci_sync_if.sv]
// tci_sync_if: bundle of synchroniser inputs and outputs.
// assumes one clock domain, mclk.
`timescale 1ns/1ps
interface tci_sync_if;
  logic [6:0] raw;
  logic [6:0] clean;
  modport syncer (input raw, output clean);
  modport user (output raw, input clean);
endinterface

// [logic/tci_sync.sv]
// tci_sync: two-flop synchroniser for pin-side levels.
// assumes inputs asynchronous to mclk; first stage read only by second.
`timescale 1ns/1ps
module tci_sync (
  input wire logic mclk,
  input wire logic rst_n,
  tci_sync_if.syncer port
);
  logic [6:0] meta_r;
  logic [6:0] meta_nxt;
  logic [6:0] clean_r;
  logic [6:0] clean_nxt;

  // next values are just the shift
  always_comb begin
    meta_nxt = port.raw;
    clean_nxt = meta_r;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 7'h00;
      clean_r <= 7'h00;
    end else begin
      meta_r <= meta_nxt;
      clean_r <= clean_nxt;
    end
  end

  assign port.clean = clean_r;
endmodule

// [logic/tci_top.sv]
// tci_top: clock select, capture routing, sync/fault routing and
// interrupt merge for three timer units, with an axi4-lite register port.
// assumes the timer-side signals are on mclk except the listed pins.
`timescale 1ns/1ps
module tci_top (
  input wire logic mclk,
  input wire logic rst_n,
  // axi4-lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // clock candidates, as enables on mclk
  input wire logic fixedFrequencyClock,
  input wire logic extClockPinA,
  input wire logic extClockPinB,
  input wire logic extClockPinC,
  output logic [2:0] timerCountTick,
  // serial port and pins
  input wire logic serialATransmit,
  output logic serialATxPin,
  input wire logic serialAReceive,
  input wire logic portABitSix,
  input wire logic portABitSeven,
  input wire logic captureAPin1,
  input wire logic captureBPin0,
  input wire logic captureBPin1,
  // on-chip sources, on mclk
  input wire logic analogComparatorA,
  input wire logic counterOverflow,
  input wire logic timerAPwm0,
  input wire logic [2:0] timerIrqSrcA,
  input wire logic [1:0] timerIrqSrcB,
  input wire logic [7:0] timerIrqSrcC,
  // routed timer inputs
  output logic timerACapture1,
  output logic timerBCapture0,
  output logic timerBCapture1,
  output logic [2:0] timerCSyncTrigger,
  output logic [3:0] timerCFault,
  output logic [2:0] timerIrqReq,
  output logic irq
);
  logic [tci_pkg::OPT_W-1:0] opt_r;
  logic [tci_pkg::OPT_W-1:0] opt_nxt;
  logic syncPulse_r;
  logic syncPulse_nxt;
  logic [5:0] clkSel_r;
  logic [5:0] clkSel_nxt;
  logic [2:0] irqStat_r;
  logic [2:0] irqStat_nxt;
  logic [2:0] irqEn_r;
  logic [2:0] irqEn_nxt;
  tci_pkg::tci_wr_type wrState_r;
  tci_pkg::tci_wr_type wrState_nxt;
  logic [7:0] wAddr_r;
  logic [7:0] wAddr_nxt;
  logic [31:0] wData_r;
  logic [31:0] wData_nxt;
  logic [3:0] wStrb_r;
  logic [3:0] wStrb_nxt;
  logic haveAddr_r;
  logic haveAddr_nxt;
  logic haveData_r;
  logic haveData_nxt;
  logic [1:0] bresp_r;
  logic [1:0] bresp_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [1:0] rresp_r;
  logic [1:0] rresp_nxt;
  logic [2:0] tick_r;
  logic [2:0] tick_nxt;
  logic [9:0] route_r;
  logic [9:0] route_nxt;
  logic [2:0] merged;
  logic doWrite;
  tci_sync_if pins ();

  // pin-side inputs except captureBPin0 and captureBPin1 pass two flops before any use
  assign pins.raw = {portABitSeven, portABitSix, extClockPinC, extClockPinB, extClockPinA,
    serialAReceive, captureAPin1};
  tci_sync u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .port(pins)
  );

  // pick one count enable from a 2-bit source code
  function automatic logic pick_clock(input logic [1:0] code, input logic ext);
    case (code)
      tci_pkg::SRC_BUS: pick_clock = 1'b1;
      tci_pkg::SRC_FIXED: pick_clock = fixedFrequencyClock;
      tci_pkg::SRC_EXT: pick_clock = ext;
      default: pick_clock = 1'b0;
    endcase
  endfunction

  // is a byte address write-mapped
  function automatic logic wr_mapped(input logic [7:0] a);
    wr_mapped = (a == tci_pkg::OFS_OPTIONS) || (a == tci_pkg::OFS_CLKSEL) ||
      (a == tci_pkg::OFS_IRQ_ENABLE) || (a == tci_pkg::OFS_IRQ_CLEAR);
  endfunction

  // write channel: address and data taken in either order
  always_comb begin
    wrState_nxt = wrState_r;
    wAddr_nxt = wAddr_r;
    wData_nxt = wData_r;
    wStrb_nxt = wStrb_r;
    haveAddr_nxt = haveAddr_r;
    haveData_nxt = haveData_r;
    bresp_nxt = bresp_r;
    doWrite = 1'b0;
    case (wrState_r)
      tci_pkg::WR_IDLE: begin
        if (awvalid && !haveAddr_r) begin
          wAddr_nxt = awaddr;
          haveAddr_nxt = 1'b1;
        end
        if (wvalid && !haveData_r) begin
          wData_nxt = wdata;
          wStrb_nxt = wstrb;
          haveData_nxt = 1'b1;
        end
        if (haveAddr_nxt && haveData_nxt) begin
          wrState_nxt = tci_pkg::WR_TAKE;
        end
      end
      tci_pkg::WR_TAKE: begin
        doWrite = 1'b1;
        bresp_nxt = wr_mapped(wAddr_r) ? tci_pkg::RESP_OKAY : tci_pkg::RESP_SLVERR;
        wrState_nxt = tci_pkg::WR_RESP;
      end
      tci_pkg::WR_RESP: begin
        if (bready) begin
          haveAddr_nxt = 1'b0;
          haveData_nxt = 1'b0;
          wrState_nxt = tci_pkg::WR_IDLE;
        end
      end
      default: wrState_nxt = tci_pkg::WR_IDLE;
    endcase
  end

  assign awready = (wrState_r == tci_pkg::WR_IDLE) && !haveAddr_r;
  assign wready = (wrState_r == tci_pkg::WR_IDLE) && !haveData_r;
  assign bvalid = (wrState_r == tci_pkg::WR_RESP);
  assign bresp = bresp_r;

  // registers written by software; only byte lane 0 carries fields
  always_comb begin
    opt_nxt = opt_r;
    clkSel_nxt = clkSel_r;
    irqEn_nxt = irqEn_r;
    syncPulse_nxt = 1'b0;
    irqStat_nxt = irqStat_r;
    if (doWrite && wStrb_r[0]) begin
      if (wAddr_r == tci_pkg::OFS_OPTIONS) begin
        opt_nxt = wData_r[tci_pkg::OPT_W-1:0];
        syncPulse_nxt = wData_r[tci_pkg::BIT_SYNC]; // self-clearing
      end else if (wAddr_r == tci_pkg::OFS_CLKSEL) begin
        clkSel_nxt = wData_r[5:0];
      end else if (wAddr_r == tci_pkg::OFS_IRQ_ENABLE) begin
        irqEn_nxt = wData_r[2:0];
      end else if (wAddr_r == tci_pkg::OFS_IRQ_CLEAR) begin
        irqStat_nxt = irqStat_r & ~wData_r[2:0];
      end
    end
    // a new event wins over a clear in the same cycle
    irqStat_nxt = irqStat_nxt | merged;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wrState_r <= tci_pkg::WR_IDLE;
      wAddr_r <= 8'h00;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
      haveAddr_r <= 1'b0;
      haveData_r <= 1'b0;
      bresp_r <= tci_pkg::RESP_OKAY;
      opt_r <= tci_pkg::OPT_RESET;
      syncPulse_r <= 1'b0;
      clkSel_r <= tci_pkg::CLKSEL_RESET;
      irqEn_r <= tci_pkg::IRQ_RESET;
      irqStat_r <= tci_pkg::IRQ_RESET;
    end else begin
      wrState_r <= wrState_nxt;
      wAddr_r <= wAddr_nxt;
      wData_r <= wData_nxt;
      wStrb_r <= wStrb_nxt;
      haveAddr_r <= haveAddr_nxt;
      haveData_r <= haveData_nxt;
      bresp_r <= bresp_nxt;
      opt_r <= opt_nxt;
      syncPulse_r <= syncPulse_nxt;
      clkSel_r <= clkSel_nxt;
      irqEn_r <= irqEn_nxt;
      irqStat_r <= irqStat_nxt;
    end
  end

  // read channel: one-cycle answer, rvalid held until rready
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (rvalid_r) begin
      if (rready) begin
        rvalid_nxt = 1'b0;
      end
    end else if (arvalid) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = tci_pkg::RESP_OKAY;
      rdata_nxt = 32'h00000000;
      if (araddr == tci_pkg::OFS_OPTIONS) begin
        rdata_nxt[tci_pkg::OPT_W-1:0] = opt_r; // sync bit reads zero
      end else if (araddr == tci_pkg::OFS_CLKSEL) begin
        rdata_nxt[5:0] = clkSel_r;
      end else if (araddr == tci_pkg::OFS_IRQ_STATUS) begin
        rdata_nxt[2:0] = irqStat_r;
      end else if (araddr == tci_pkg::OFS_IRQ_ENABLE) begin
        rdata_nxt[2:0] = irqEn_r;
      end else if (araddr == tci_pkg::OFS_IRQ_CLEAR) begin
        rdata_nxt = 32'h00000000; // write-only
      end else if (araddr == tci_pkg::OFS_LIVE) begin
        rdata_nxt[2:0] = merged;
      end else begin
        rresp_nxt = tci_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= tci_pkg::RESP_OKAY;
    end else begin
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign arready = !rvalid_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  // per-timer count enables; code 00 leaves the counter stopped
  always_comb begin
    tick_nxt[0] = pick_clock(clkSel_r[tci_pkg::CLK_POS_A +: 2], pins.clean[2]);
    // small packages have no b/c pins; software avoids code 11 there
    tick_nxt[1] = pick_clock(clkSel_r[tci_pkg::CLK_POS_B +: 2], pins.clean[3]);
    tick_nxt[2] = pick_clock(clkSel_r[tci_pkg::CLK_POS_C +: 2], pins.clean[4]);
  end

  // routed signals, registered so every routed output leaves a flop
  always_comb begin
    route_nxt[0] = opt_r[tci_pkg::BIT_TXMOD] ? (serialATransmit & timerAPwm0)
      : serialATransmit;
    route_nxt[1] = opt_r[tci_pkg::BIT_RXCAP] ? pins.clean[1] : pins.clean[0];
    route_nxt[2] = opt_r[tci_pkg::BIT_CMPCAP] ? analogComparatorA : captureBPin0;
    route_nxt[3] = opt_r[tci_pkg::BIT_RTCCAP] ? counterOverflow : captureBPin1;
    route_nxt[4] = analogComparatorA;
    route_nxt[5] = timerAPwm0;
    route_nxt[6] = syncPulse_r;
    route_nxt[7] = analogComparatorA;
    route_nxt[8] = pins.clean[5];
    route_nxt[9] = pins.clean[6];
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick_r <= 3'h0;
      route_r <= 10'h000;
    end else begin
      tick_r <= tick_nxt;
      route_r <= route_nxt;
    end
  end

  // one request line per timer, any source fires it
  assign merged = {|timerIrqSrcC, |timerIrqSrcB, |timerIrqSrcA};

  assign timerCountTick = tick_r;
  assign serialATxPin = route_r[0];
  assign timerACapture1 = route_r[1];
  assign timerBCapture0 = route_r[2];
  assign timerBCapture1 = route_r[3];
  assign timerCSyncTrigger = route_r[6:4];
  assign timerCFault = {1'b0, route_r[9:7]}; // fault 3 held inactive
  assign timerIrqReq = merged;
  assign irq = |(irqStat_r & irqEn_r);
endmodule

// [tb/tci_far_model.sv]
// tci_far_model: timer units, comparator, counter and serial port beside the block.
// assumes ctl is set by the bench on mclk; every output is an mclk level.
`timescale 1ns/1ps
module tci_far_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [5:0] ctl,
  output logic analogComparatorA,
  output logic counterOverflow,
  output logic timerAPwm0,
  output logic serialATransmit,
  output logic [2:0] timerIrqSrcA,
  output logic [1:0] timerIrqSrcB,
  output logic [7:0] timerIrqSrcC
);
  logic [5:0] ctl_r;
  // registered, as real units launch their levels on mclk
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_r <= 6'h00;
    end else begin
      ctl_r <= ctl;
    end
  end
  assign {serialATransmit, timerAPwm0, counterOverflow, analogComparatorA} = ctl_r[3:0];
  // each unit keeps its own flags; only one level per source leaves it
  assign timerIrqSrcA = {2'h0, ctl_r[4]};
  assign timerIrqSrcB = {ctl_r[5], 1'h0};
  assign timerIrqSrcC = {ctl_r[5], 7'h00};
endmodule

// [tb/tci_checker.sv]
// tci_checker: bus and routing properties seen at the ports of tci_top.
// assumes one clock mclk and asynchronous active-low rst_n; bound below.
`timescale 1ns/1ps
module tci_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic analogComparatorA,
  input wire logic timerAPwm0,
  input wire logic [2:0] timerIrqSrcA,
  input wire logic [1:0] timerIrqSrcB,
  input wire logic [7:0] timerIrqSrcC,
  input wire logic [2:0] timerIrqReq,
  input wire logic [2:0] timerCSyncTrigger,
  input wire logic [3:0] timerCFault
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // both write halves taken together, then the answer two edges on
  sequence wrBoth;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence wrAnswer;
    !bvalid ##1 bvalid;
  endsequence
  chk_write_answer: assert property (wrBoth |=> wrAnswer)
    else $error("write response not on time");
  chk_bus_refuse: assert property (wrBoth |=> !awready && !wready)
    else $error("write channels still ready");
  chk_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read data not on time");
  chk_resp_drop: assert property (bvalid && bready |=> !bvalid)
    else $error("write response held after handshake");
  chk_sync_pulse: assert property ($rose(timerCSyncTrigger[2]) |=> !timerCSyncTrigger[2])
    else $error("software trigger longer than one cycle");
  chk_trig_follow: assert property ($past(rst_n) |-> timerCSyncTrigger[1] == $past(timerAPwm0)
    && timerCSyncTrigger[0] == $past(analogComparatorA))
    else $error("sync trigger not routed");
  chk_fault_route: assert property ($past(rst_n) |->
    timerCFault[0] == $past(analogComparatorA) && !timerCFault[3])
    else $error("fault input wrong");
  chk_irq_merge: assert property (timerIrqReq ==
    {|timerIrqSrcC, |timerIrqSrcB, |timerIrqSrcA})
    else $error("merged request wrong");
endmodule
bind tci_top tci_checker u_chk (.*);

// [tb/tb.sv]
// tb: register-level tests of tci_top through its axi4-lite port.
// assumes tci_far_model on the timer side; pins are driven here.
`timescale 1ns/1ps
module tb;
  logic mclk = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hF;
  logic fixedFrequencyClock = 1'h0, extClockPinA = 1'h0, extClockPinB = 1'h0;
  logic extClockPinC = 1'h0, serialAReceive = 1'h0, portABitSix = 1'h0;
  logic portABitSeven = 1'h0, captureAPin1 = 1'h0, captureBPin0 = 1'h0, captureBPin1 = 1'h0;
  logic [5:0] farCtl = 6'h00;
  logic awready, wready, bvalid, arready, rvalid, irq, serialATxPin;
  logic analogComparatorA, counterOverflow, timerAPwm0, serialATransmit;
  logic timerACapture1, timerBCapture0, timerBCapture1;
  logic [1:0] bresp, rresp, resp, timerIrqSrcB;
  logic [2:0] timerIrqSrcA, timerCountTick, timerIrqReq, timerCSyncTrigger;
  logic [7:0] timerIrqSrcC;
  logic [3:0] timerCFault;
  logic [31:0] rdata, got;
  int err_count = 0;
  int check_count = 0;
  int n;
  tci_top DUT (.*);
  tci_far_model far_u (.*, .ctl(farCtl));
  // free-running bus clock, 8 ns
  initial begin
    forever #4 mclk = !mclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // write: both halves offered at once, each dropped once taken
  // no cycle limit here: only the watchdog ends a wait that never answers
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    got = rdata;
    resp = rresp;
    rready <= 1'h0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(got, e, "read");
  endtask
  // pin levels need two sync flops plus the output register
  task automatic wt();
    repeat (5) @(posedge mclk);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // watchdog: the whole sequence needs a few hundred cycles
  initial begin
    #100000;
    err_count++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'h1;
    rc(tci_pkg::OFS_OPTIONS, 32'h00000000);
    rc(tci_pkg::OFS_CLKSEL, 32'h00000000);
    chk({30'h0, resp}, {30'h0, tci_pkg::RESP_OKAY}, "rd resp");
    rd(8'h20);
    chk({30'h0, resp}, {30'h0, tci_pkg::RESP_SLVERR}, "unmapped");
    // a write to an unmapped word must be refused and leave the options alone
    wr(8'h18, 32'h0000001F);
    chk({30'h0, resp}, {30'h0, tci_pkg::RESP_SLVERR}, "wr unmapped");
    rc(tci_pkg::OFS_OPTIONS, 32'h00000000);
    $display("test reset done");
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 4; c++) begin
        logic e;
        e = (c == 1) || (c == 2 && p == 0) || (c == 3 && p == 1);
        fixedFrequencyClock <= !p[0];
        extClockPinA <= p[0];
        wr(tci_pkg::OFS_CLKSEL, {26'h0, 2'h1, 2'h1, c[1:0]});
        wt();
        chk({29'h0, timerCountTick}, {29'h0, 2'h3, e}, "tick");
      end
    end
    $display("test clocks done");
    for (int q = 0; q < 2; q++) begin
      for (int p = 0; p < 2; p++) begin
        logic e;
        e = p[0] ^ q[0];
        {captureAPin1, captureBPin0, captureBPin1, portABitSix} <= {4{p[0]}};
        {serialAReceive, portABitSeven} <= {2{!p[0]}};
        farCtl[3:0] <= {1'h1, p[0], !p[0], !p[0]};
        wr(tci_pkg::OFS_OPTIONS, q ? 32'h0000000F : 32'h00000000);
        wt();
        chk({29'h0, timerACapture1, timerBCapture0, timerBCapture1},
          {29'h0, {3{e}}}, "cap");
        chk({31'h0, serialATxPin}, {31'h0, !q[0] || p[0]}, "tx");
        chk({26'h0, timerCSyncTrigger[1:0], timerCFault},
          {26'h0, p[0], !p[0], 1'h0, !p[0], p[0], !p[0]}, "trig fault");
      end
    end
    $display("test routes done");
    wr(tci_pkg::OFS_OPTIONS, 32'h00000010);
    chk({30'h0, resp}, {30'h0, tci_pkg::RESP_OKAY}, "wr resp");
    n = 0;
    repeat (6) begin
      @(posedge mclk);
      n += timerCSyncTrigger[2];
    end
    chk(n, 32'h1, "sync pulse");
    rc(tci_pkg::OFS_OPTIONS, 32'h00000000);
    $display("test sync done");
    wr(tci_pkg::OFS_IRQ_ENABLE, 32'h00000001);
    farCtl[4] <= 1'h1;
    wt();
    rc(tci_pkg::OFS_IRQ_STATUS, 32'h00000001);
    chk({31'h0, irq}, 32'h1, "irq set");
    farCtl[5:4] <= 2'h2;
    wt();
    rc(tci_pkg::OFS_LIVE, 32'h00000006);
    wr(tci_pkg::OFS_IRQ_ENABLE, 32'h00000000);
    wt();
    chk({31'h0, irq}, 32'h0, "irq masked");
    // sources b and c still high: their bits must survive a clear, bit a must go
    wr(tci_pkg::OFS_IRQ_CLEAR, 32'h00000007);
    rc(tci_pkg::OFS_IRQ_STATUS, 32'h00000006);
    farCtl[5:4] <= 2'h0;
    wt();
    wr(tci_pkg::OFS_IRQ_CLEAR, 32'h00000007);
    rc(tci_pkg::OFS_IRQ_STATUS, 32'h00000000);
    $display("test irq done");
    conclude();
  end
endmodule
